/* rtl/tgcd_top.sv */
// command decoder and per-counter gating for a five-counter timing controller
// assumes the counting core supplies terminal_count on ref_clk; gate pins are asynchronous
//
// Overview of operation
// - code 000 counts whenever armed
// - code 100 counts while own gate high
// - code 101 counts while own gate low
// - codes 010/011 use upper/lower neighbour gate
// - counters one and five are neighbours
// - codes 110/111 run from edge until terminal count
// - repeating edge mode stays armed and waits for a new edge after terminal count
// - code 001 gates on lower terminal count
// - host writes 8-bit command, device decodes it
// - select field bit per counter, bit0 first
// - single commands address one counter, 1 to 5
// - top bits pick the multi-counter operation
// - top 000 loads data pointer, two groups excluded
// - set, clear toggle, or step one counter
// - fixed codes set or clear master bits
// - prefetch on/off codes and master reset
// - arm enables counting, clear bits untouched
// - disarm during terminal count waits for exit
// - arm resets alternating reload to hold first
// - without repetition disarm after one cycle
`timescale 1ns/1ps
`default_nettype none

module tgcd_top
    import tgcd_pkg::*;
(
    input  wire logic                    ref_clk,
    input  wire logic                    reset,
    input  wire logic                    clk_en,
    input  wire logic                    cmd_write,
    input  wire logic [7:0]              cmd_data,
    input  wire logic [NUM_COUNTERS-1:0] own_gate_pin,
    input  wire logic [NUM_COUNTERS-1:0] terminal_count,
    input  wire tgcd_mode_t              counter_mode [NUM_COUNTERS],
    output logic [NUM_COUNTERS-1:0]      count_enable,
    output logic [NUM_COUNTERS-1:0]      armed,
    output logic [NUM_COUNTERS-1:0]      load_pulse,
    output logic [NUM_COUNTERS-1:0]      save_pulse,
    output logic [NUM_COUNTERS-1:0]      step_pulse,
    output logic [NUM_COUNTERS-1:0]      toggle_state,
    output logic [NUM_COUNTERS-1:0]      reload_from_hold,
    output tgcd_pointer_t                data_pointer,
    output tgcd_master_t                 master_mode,
    output logic                         master_reset_pulse
);

    localparam int LAST = NUM_COUNTERS - 1;

    // wrap-around neighbours
    function automatic int upper_index(input int idx);
        return (idx == LAST) ? 0 : idx + 1;
    endfunction

    function automatic int lower_index(input int idx);
        return (idx == 0) ? LAST : idx - 1;
    endfunction

    // counter number to one-hot
    function automatic logic [NUM_COUNTERS-1:0] number_to_select(input logic [2:0] number);
        logic [NUM_COUNTERS-1:0] sel;
        sel = COUNTER_RESET;
        for (int k = 0; k < NUM_COUNTERS; k++) begin
            if (number == 3'(k + 1)) begin
                sel[k] = 1'b1;
            end
        end
        return sel;
    endfunction

    logic [7:0]              command_entry;
    logic                    command_pending;
    logic [NUM_COUNTERS-1:0] gate_meta;
    logic [NUM_COUNTERS-1:0] gate_sync;
    logic [NUM_COUNTERS-1:0] gate_prev;
    logic [NUM_COUNTERS-1:0] tc_prev;
    logic [NUM_COUNTERS-1:0] disarm_pending;
    logic [NUM_COUNTERS-1:0] edge_running;
    logic                    soft_reset;

    // decoded command strobes
    logic [2:0]              cmd_op;
    logic [4:0]              cmd_prefix;
    logic [NUM_COUNTERS-1:0] cmd_select;
    logic [NUM_COUNTERS-1:0] cmd_number_sel;
    logic [NUM_COUNTERS-1:0] do_arm;
    logic [NUM_COUNTERS-1:0] do_load;
    logic [NUM_COUNTERS-1:0] do_save;
    logic [NUM_COUNTERS-1:0] do_disarm;
    logic [NUM_COUNTERS-1:0] do_step;
    logic [NUM_COUNTERS-1:0] do_set_toggle;
    logic [NUM_COUNTERS-1:0] do_clear_toggle;
    logic                    do_pointer;
    logic [NUM_COUNTERS-1:0] tc_rise;
    logic [NUM_COUNTERS-1:0] tc_fall;
    logic [NUM_COUNTERS-1:0] gate_rise;
    logic [NUM_COUNTERS-1:0] gate_fall;
    logic [NUM_COUNTERS-1:0] next_armed;
    logic [NUM_COUNTERS-1:0] next_count_enable;
    logic [NUM_COUNTERS-1:0] next_edge_running;

    // command capture, decoded one cycle later
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            command_entry   <= COMMAND_RESET;
            command_pending <= 1'b0;
        end else if (clk_en) begin
            command_pending <= cmd_write;
            if (cmd_write) begin
                command_entry <= cmd_data;
            end
        end
    end

    // gate pins cross into ref_clk through two flops
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            gate_meta <= COUNTER_RESET;
            gate_sync <= COUNTER_RESET;
            gate_prev <= COUNTER_RESET;
            tc_prev   <= COUNTER_RESET;
        end else if (clk_en) begin
            gate_meta <= own_gate_pin;
            gate_sync <= gate_meta;
            gate_prev <= gate_sync;
            tc_prev   <= terminal_count;
        end
    end

    assign cmd_op         = command_entry[7:5];
    assign cmd_prefix     = command_entry[7:3];
    assign cmd_select     = command_entry[4:0];
    assign cmd_number_sel = number_to_select(command_entry[2:0]);
    assign tc_rise        = terminal_count & ~tc_prev;
    assign tc_fall        = ~terminal_count & tc_prev;
    assign gate_rise      = gate_sync & ~gate_prev;
    assign gate_fall      = ~gate_sync & gate_prev;

    // one decode drives every selected counter in the same cycle
    always_comb begin
        do_arm          = COUNTER_RESET;
        do_load         = COUNTER_RESET;
        do_save         = COUNTER_RESET;
        do_disarm       = COUNTER_RESET;
        do_step         = COUNTER_RESET;
        do_set_toggle   = COUNTER_RESET;
        do_clear_toggle = COUNTER_RESET;
        do_pointer      = 1'b0;
        if (command_pending) begin
            unique case (cmd_op)
                OP_POINTER: begin
                    do_pointer = (command_entry[2:0] != GROUP_EXCLUDED_A)
                              && (command_entry[2:0] != GROUP_EXCLUDED_B);
                end
                OP_ARM: begin
                    do_arm = cmd_select;
                end
                OP_LOAD: begin
                    do_load = cmd_select;
                end
                OP_LOAD_ARM: begin
                    do_load = cmd_select;
                    do_arm  = cmd_select;
                end
                OP_DISARM_SAVE: begin
                    do_disarm = cmd_select;
                    do_save   = cmd_select;
                end
                OP_SAVE: begin
                    do_save = cmd_select;
                end
                OP_DISARM: begin
                    do_disarm = cmd_select;
                end
                OP_SINGLE: begin
                    if (cmd_prefix == PFX_SET_TOGGLE) begin
                        do_set_toggle = cmd_number_sel;
                    end else if (cmd_prefix == PFX_CLEAR_TOGGLE) begin
                        do_clear_toggle = cmd_number_sel;
                    end else if (cmd_prefix == PFX_STEP) begin
                        do_step = cmd_number_sel;
                    end
                end
            endcase
        end
    end

    assign soft_reset = command_pending && (command_entry == CODE_MASTER_RESET);

    // arm state
    always_comb begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            next_armed[i] = armed[i];
            if (disarm_pending[i] && (tc_fall[i] || do_load[i] || do_step[i])) begin
                next_armed[i] = 1'b0;
            end
            if (armed[i] && tc_fall[i] && !counter_mode[i].repetition_bit) begin
                next_armed[i] = 1'b0;
            end
            if (do_disarm[i] && !terminal_count[i]) begin
                next_armed[i] = 1'b0;
            end
            if (do_arm[i]) begin
                next_armed[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            armed          <= COUNTER_RESET;
            disarm_pending <= COUNTER_RESET;
        end else if (clk_en) begin
            armed <= next_armed;
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                if (do_arm[i] || tc_fall[i] || do_load[i] || do_step[i]) begin
                    disarm_pending[i] <= 1'b0;
                end
                if (do_disarm[i] && terminal_count[i] && !do_arm[i]) begin
                    disarm_pending[i] <= 1'b1;
                end
            end
        end
    end

    // edge-triggered run windows
    always_comb begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            next_edge_running[i] = edge_running[i];
            if (tc_rise[i]) begin
                next_edge_running[i] = 1'b0;
            end else if (!edge_running[i]) begin
                // edges ignored inside a window
                if (counter_mode[i].gate_select == GATE_EDGE_RISE) begin
                    next_edge_running[i] = gate_rise[i];
                end else if (counter_mode[i].gate_select == GATE_EDGE_FALL) begin
                    next_edge_running[i] = gate_fall[i];
                end
            end
            if (!next_armed[i]) begin
                next_edge_running[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            edge_running <= COUNTER_RESET;
        end else if (clk_en) begin
            edge_running <= next_edge_running;
        end
    end

    // gate condition, qualified by arm
    always_comb begin
        for (int i = 0; i < NUM_COUNTERS; i++) begin
            unique case (counter_mode[i].gate_select)
                GATE_NONE:      next_count_enable[i] = 1'b1;
                GATE_LOWER_TC:  next_count_enable[i] = terminal_count[lower_index(i)];
                GATE_UPPER_PIN: next_count_enable[i] = gate_sync[upper_index(i)];
                GATE_LOWER_PIN: next_count_enable[i] = gate_sync[lower_index(i)];
                GATE_OWN_HIGH:  next_count_enable[i] = gate_sync[i];
                GATE_OWN_LOW:   next_count_enable[i] = ~gate_sync[i];
                GATE_EDGE_RISE,
                GATE_EDGE_FALL: next_count_enable[i] = next_edge_running[i];
            endcase
            next_count_enable[i] = next_count_enable[i] & next_armed[i];
        end
    end

    // strobes to the counting core
    always_ff @(posedge ref_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            count_enable <= COUNTER_RESET;
            load_pulse   <= COUNTER_RESET;
            save_pulse   <= COUNTER_RESET;
            step_pulse   <= COUNTER_RESET;
        end else if (clk_en) begin
            count_enable <= next_count_enable;
            load_pulse   <= do_load;
            save_pulse   <= do_save;
            step_pulse   <= do_step;
        end
    end

    // toggle flip-flops
    always_ff @(posedge ref_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            toggle_state <= COUNTER_RESET;
        end else if (clk_en) begin
            toggle_state <= (toggle_state | do_set_toggle) & ~do_clear_toggle;
        end
    end

    // alternating reload source
    always_ff @(posedge ref_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            reload_from_hold <= COUNTER_RESET;
        end else if (clk_en) begin
            for (int i = 0; i < NUM_COUNTERS; i++) begin
                if (!counter_mode[i].alternate_reload) begin
                    reload_from_hold[i] <= 1'b0;
                end else if (do_arm[i]) begin
                    reload_from_hold[i] <= 1'b1;
                end else if (tc_rise[i]) begin
                    reload_from_hold[i] <= ~reload_from_hold[i];
                end
            end
        end
    end

    // data pointer and master-mode bits
    always_ff @(posedge ref_clk) begin
        if (reset || (clk_en && soft_reset)) begin
            data_pointer <= POINTER_RESET;
            master_mode  <= MASTER_RESET;
        end else if (clk_en && command_pending) begin
            if (do_pointer) begin
                data_pointer.element      <= command_entry[4:3];
                data_pointer.group        <= command_entry[2:0];
                data_pointer.byte_pointer <= 1'b1;
            end
            unique case (command_entry)
                CODE_SEQ_DISABLE:  master_mode.pointer_sequencing_disable_bit <= 1'b1;
                CODE_SEQ_ENABLE:   master_mode.pointer_sequencing_disable_bit <= 1'b0;
                CODE_FREQUENCY_OUTPUT_OFF:     master_mode.freq_out_gate_off_bit          <= 1'b1;
                CODE_FREQUENCY_OUTPUT_ON:      master_mode.freq_out_gate_off_bit          <= 1'b0;
                CODE_BUS_WIDE:     master_mode.wide_bus_bit                   <= 1'b1;
                CODE_BUS_NARROW:   master_mode.wide_bus_bit                   <= 1'b0;
                CODE_PREFETCH_ON:  master_mode.write_prefetch                 <= 1'b1;
                CODE_PREFETCH_OFF: master_mode.write_prefetch                 <= 1'b0;
                default:           master_mode                                <= master_mode;
            endcase
        end
    end

    // master reset strobe
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            master_reset_pulse <= 1'b0;
        end else if (clk_en) begin
            master_reset_pulse <= soft_reset;
        end
    end

endmodule

`default_nettype wire

/* pkg/tgcd_pkg.sv */
// package for the timer gating and command decode block
// assumes one clock domain; shared by the design and the bench
package tgcd_pkg;

    localparam int          NUM_COUNTERS      = 5;

    // multi-counter operation in command bits 7..5
    localparam logic [2:0]  OP_POINTER        = 3'h0;
    localparam logic [2:0]  OP_ARM            = 3'h1;
    localparam logic [2:0]  OP_LOAD           = 3'h2;
    localparam logic [2:0]  OP_LOAD_ARM       = 3'h3;
    localparam logic [2:0]  OP_DISARM_SAVE    = 3'h4;
    localparam logic [2:0]  OP_SAVE           = 3'h5;
    localparam logic [2:0]  OP_DISARM         = 3'h6;
    localparam logic [2:0]  OP_SINGLE         = 3'h7;

    // single-counter prefixes in command bits 7..3
    localparam logic [4:0]  PFX_CLEAR_TOGGLE  = 5'h1c;
    localparam logic [4:0]  PFX_SET_TOGGLE    = 5'h1d;
    localparam logic [4:0]  PFX_STEP          = 5'h1e;
    localparam logic [4:0]  PFX_SPECIAL       = 5'h1f;

    // fixed master-mode codes
    localparam logic [7:0]  CODE_SEQ_DISABLE  = 8'he8;
    localparam logic [7:0]  CODE_SEQ_ENABLE   = 8'he0;
    localparam logic [7:0]  CODE_FREQUENCY_OUTPUT_OFF     = 8'hee;
    localparam logic [7:0]  CODE_FREQUENCY_OUTPUT_ON      = 8'he6;
    localparam logic [7:0]  CODE_BUS_WIDE     = 8'hef;
    localparam logic [7:0]  CODE_BUS_NARROW   = 8'he7;
    localparam logic [7:0]  CODE_PREFETCH_ON  = 8'hf8;
    localparam logic [7:0]  CODE_PREFETCH_OFF = 8'hf9;
    localparam logic [7:0]  CODE_MASTER_RESET = 8'hff;

    // excluded group values of the pointer command
    localparam logic [2:0]  GROUP_EXCLUDED_A  = 3'h0;
    localparam logic [2:0]  GROUP_EXCLUDED_B  = 3'h6;

    // gate select codes
    localparam logic [2:0]  GATE_NONE         = 3'h0;
    localparam logic [2:0]  GATE_LOWER_TC     = 3'h1;
    localparam logic [2:0]  GATE_UPPER_PIN    = 3'h2;
    localparam logic [2:0]  GATE_LOWER_PIN    = 3'h3;
    localparam logic [2:0]  GATE_OWN_HIGH     = 3'h4;
    localparam logic [2:0]  GATE_OWN_LOW      = 3'h5;
    localparam logic [2:0]  GATE_EDGE_RISE    = 3'h6;
    localparam logic [2:0]  GATE_EDGE_FALL    = 3'h7;

    // reset values
    localparam logic [7:0]  COMMAND_RESET     = 8'h00;
    localparam logic [4:0]  COUNTER_RESET     = 5'h00;

    typedef struct packed {
        logic [2:0] gate_select;
        logic       repetition_bit;
        logic       alternate_reload;
    } tgcd_mode_t;

    typedef struct packed {
        logic [1:0] element;
        logic [2:0] group;
        logic       byte_pointer;
    } tgcd_pointer_t;

    typedef struct packed {
        logic pointer_sequencing_disable_bit;
        logic freq_out_gate_off_bit;
        logic wide_bus_bit;
        logic write_prefetch;
    } tgcd_master_t;

    localparam tgcd_pointer_t POINTER_RESET = '{element: 2'h0, group: 3'h0, byte_pointer: 1'b1};
    localparam tgcd_master_t  MASTER_RESET  = '{default: 1'b0};

endpackage

/* verif/tgcd_host_model.sv */
// host model writing command bytes to the control port
// assumes the bench clock; drives just after the falling edge
`timescale 1ns/1ps
`default_nettype none
module tgcd_host_model (
    input  wire logic       ref_clk,
    output logic            cmd_write,
    output logic [7:0]      cmd_data
);
    initial begin
        cmd_write = 1'b0;
        cmd_data  = 8'h00;
    end
    // unused codes never reach the port
    function automatic bit legal(input logic [7:0] c);
        return !(c == 8'hf0 || c == 8'hf6 || c == 8'hf7 ||
                 (c[7:5] == 3'h0 && (c[2:0] == 3'h0 || c[2:0] == 3'h6)) ||
                 (c[7:3] == 5'h1f && !(c[2:0] inside {3'h0, 3'h1, 3'h7})));
    endfunction
    // one byte per write; sources stay synchronous for load-arm
    task automatic send(input logic [7:0] c);
        if (legal(c)) begin
            @(negedge ref_clk);
            cmd_write = 1'b1;
            cmd_data  = c;
            @(negedge ref_clk);
            cmd_write = 1'b0;
            cmd_data  = ~c;
        end
    endtask
endmodule
`default_nettype wire

/* verif/tgcd_top_asserts.sv */
// checker for the command decoder and gating block
// assumes binding onto tgcd_top; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module tgcd_checker
    import tgcd_pkg::*;
(
    input wire logic          ref_clk,
    input wire logic          reset,
    input wire logic          clk_en,
    input wire logic          cmd_write,
    input wire logic [7:0]    cmd_data,
    input wire logic [4:0]    terminal_count,
    input wire tgcd_mode_t    counter_mode [NUM_COUNTERS],
    input wire logic [4:0]    count_enable,
    input wire logic [4:0]    armed,
    input wire logic [4:0]    load_pulse,
    input wire logic [4:0]    save_pulse,
    input wire logic [4:0]    step_pulse,
    input wire logic [4:0]    toggle_state,
    input wire tgcd_pointer_t data_pointer,
    input wire tgcd_master_t  master_mode,
    input wire logic          master_reset_pulse
);
    logic       got;
    logic [7:0] cmd;
    logic [4:0] hot;
    logic       dec;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            got <= 1'b0;
            cmd <= 8'h00;
        end else if (clk_en) begin
            got <= cmd_write;
            cmd <= cmd_data;
        end
    end
    // one-hot counter of a single-counter command
    assign hot = 5'((6'h01 << cmd[2:0]) >> 1);
    assign dec = got && clk_en;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_arm_sets: assert property (dec && cmd[7:5] == OP_ARM |=>
        (armed & $past(cmd[4:0])) == $past(cmd[4:0])) else $error("arm missed");
    chk_arm_keeps: assert property (dec && cmd[7:5] == OP_ARM |=>
        (armed & ~$past(armed) & ~$past(cmd[4:0])) == 5'h00) else $error("arm stray");
    chk_load_pulse: assert property (dec && (cmd[7:5] == OP_LOAD || cmd[7:5] == OP_LOAD_ARM) |=>
        load_pulse == $past(cmd[4:0])) else $error("load pulse");
    chk_save_pulse: assert property (dec && (cmd[7:5] == OP_SAVE || cmd[7:5] == OP_DISARM_SAVE) |=>
        save_pulse == $past(cmd[4:0])) else $error("save pulse");
    chk_disarm_now: assert property (dec && (cmd[7:5] == OP_DISARM || cmd[7:5] == OP_DISARM_SAVE) &&
        (terminal_count & cmd[4:0]) == 5'h00 |=> (armed & $past(cmd[4:0])) == 5'h00) else $error("disarm missed");
    chk_disarm_defer: assert property (dec && cmd[7:5] == OP_DISARM && cmd[4:0] != 5'h00 &&
        (terminal_count & cmd[4:0]) == cmd[4:0] |=> (armed & $past(cmd[4:0])) == ($past(armed) & $past(cmd[4:0])))
        else $error("no defer");
    chk_toggle_set: assert property (dec && cmd[7:3] == PFX_SET_TOGGLE |=>
        (toggle_state & $past(hot)) == $past(hot)) else $error("toggle not set");
    chk_step_one: assert property (dec && cmd[7:3] == PFX_STEP |=> step_pulse == $past(hot))
        else $error("step pulse");
    chk_pointer_load: assert property (dec && cmd[7:5] == OP_POINTER && cmd[2:0] != GROUP_EXCLUDED_A &&
        cmd[2:0] != GROUP_EXCLUDED_B |=> data_pointer == {$past(cmd[4:0]), 1'b1}) else $error("pointer wrong");
    chk_master_bit: assert property (dec && cmd[7:4] == 4'he && !(cmd[2:0] inside {[3'h1:3'h5]}) |=>
        $past(cmd[3]) == master_mode[$past(cmd[2:0]) == 3'h0 ? 3 : $past(cmd[0]) ? 1 : 2]) else $error("master bit");
    chk_mreset_pulse: assert property (dec && cmd == CODE_MASTER_RESET |-> ##[1:2] master_reset_pulse)
        else $error("no reset pulse");
    chk_gate_none: assert property ($past(counter_mode[3].gate_select) == GATE_NONE |->
        count_enable[3] == armed[3]) else $error("ungated enable");
    chk_enable_armed: assert property ((count_enable & ~armed) == 5'h00)
        else $error("count without arm");
    cover property (dec && cmd[7:5] == OP_ARM);
    cover property (dec && cmd == CODE_MASTER_RESET);
    cover property (armed[3] && terminal_count[3] && dec && cmd[7:5] == OP_DISARM);
endmodule
bind tgcd_top tgcd_checker u_tgcd_checker (.*);
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the command decoder and gating block
// assumes tgcd_top, the host model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tgcd_pkg::*;
    logic          ref_clk, reset, clk_en, cmd_write, master_reset_pulse;
    logic [7:0]    cmd_data;
    logic [4:0]    own_gate_pin, terminal_count, count_enable, armed;
    logic [4:0]    load_pulse, save_pulse, step_pulse, toggle_state, reload_from_hold;
    tgcd_mode_t    mode [NUM_COUNTERS];
    tgcd_pointer_t data_pointer, p;
    tgcd_master_t  master_mode, m;
    logic [31:0]   seed, r;
    logic [4:0]    a, s, h;
    logic [2:0]    op;
    logic [7:0]    codes [8];
    int            fail_count, total_checks;

    tgcd_top u_tgcd_top (.*, .counter_mode(mode));
    tgcd_host_model u_tgcd_host_model (.*);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [4:0] next_arm(logic [2:0] o, logic [4:0] sel, logic [4:0] cur);
        if (o == OP_ARM || o == OP_LOAD_ARM) return cur | sel;
        if (o == OP_DISARM || o == OP_DISARM_SAVE) return cur & ~sel;
        return cur;
    endfunction
    // expected enables with every counter armed
    function automatic logic [4:0] gate_exp(logic [4:0] g, logic [4:0] tc);
        logic [4:0] e;
        for (int i = 0; i < 5; i++) begin
            case (mode[i].gate_select)
                GATE_NONE:      e[i] = 1'b1;
                GATE_LOWER_TC:  e[i] = tc[(i + 4) % 5];
                GATE_UPPER_PIN: e[i] = g[(i + 1) % 5];
                GATE_LOWER_PIN: e[i] = g[(i + 4) % 5];
                GATE_OWN_HIGH:  e[i] = g[i];
                default:        e[i] = !g[i];
            endcase
        end
        return e;
    endfunction

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic cmd(input logic [7:0] c);
        u_tgcd_host_model.send(c);
        @(negedge ref_clk);
    endtask
    task automatic wait_en();
        int k = 0;
        while (count_enable[0] !== 1'b1 && k < 10) begin
            @(negedge ref_clk);
            k++;
        end
        if (count_enable[0] !== 1'b1) begin
            fail_count++;
            test_done();
        end
    endtask
    task automatic tc_pulse(input int i);
        terminal_count[i] = 1'b1;
        @(negedge ref_clk);
        terminal_count[i] = 1'b0;
        repeat (3) @(negedge ref_clk);
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end

    initial begin
        {reset, clk_en, own_gate_pin, terminal_count} = {2'b11, 10'h000};
        {fail_count, total_checks, seed, a, m} = {64'h0, 32'h42ef, 9'h000};
        p = POINTER_RESET;
        foreach (mode[i]) mode[i] = '{GATE_NONE, 1'b1, 1'b0};
        repeat (16) @(negedge ref_clk);
        reset = 1'b0;
        for (int k = 0; k < 18; k++) begin
            r = rnd();
            op = 3'(k % 6 + 1);
            s = (k < 6) ? 5'h1f : r[4:0];
            cmd({op, s});
            a = next_arm(op, s, a);
            chk("armed", armed, a);
            chk("load", load_pulse, (op == OP_LOAD || op == OP_LOAD_ARM) ? s : 5'h00);
            chk("save", save_pulse, (op == OP_SAVE || op == OP_DISARM_SAVE) ? s : 5'h00);
            chk("enable", count_enable, a);
        end
        $display("test multi done");
        for (int n = 1; n <= 5; n++) begin
            h = 5'h01 << (n - 1);
            cmd({PFX_SET_TOGGLE, 3'(n)});
            chk("toggle_set", toggle_state, h);
            cmd({PFX_STEP, 3'(n)});
            chk("step", step_pulse, h);
            cmd({PFX_CLEAR_TOGGLE, 3'(n)});
            chk("toggle_clr", toggle_state, 5'h00);
        end
        $display("test single done");
        codes = '{CODE_SEQ_DISABLE, CODE_FREQUENCY_OUTPUT_OFF, CODE_BUS_WIDE, CODE_PREFETCH_ON,
                  CODE_SEQ_ENABLE, CODE_FREQUENCY_OUTPUT_ON, CODE_BUS_NARROW, CODE_PREFETCH_OFF};
        foreach (codes[i]) begin
            cmd(codes[i]);
            m = (i < 4) ? m | (4'h8 >> i) : m & ~(4'h8 >> (i - 4));
            chk("master", master_mode, m);
        end
        for (int k = 0; k < 8; k++) begin
            r = rnd();
            cmd({3'h0, r[4:0]});
            if (r[2:0] != GROUP_EXCLUDED_A && r[2:0] != GROUP_EXCLUDED_B) p = {r[4:0], 1'b1};
            chk("pointer", data_pointer, p);
        end
        $display("test master done");
        mode[0] = '{GATE_OWN_HIGH, 1'b1, 1'b0};
        mode[1] = '{GATE_LOWER_PIN, 1'b1, 1'b0};
        mode[2] = '{GATE_OWN_LOW, 1'b1, 1'b0};
        mode[3] = '{GATE_LOWER_TC, 1'b1, 1'b0};
        mode[4] = '{GATE_UPPER_PIN, 1'b1, 1'b0};
        cmd(8'h3f);
        for (int k = 0; k < 10; k++) begin
            r = rnd();
            own_gate_pin = r[4:0];
            terminal_count = {2'b00, r[7], 2'b00};
            repeat (4) @(negedge ref_clk);
            chk("gated", count_enable, gate_exp(own_gate_pin, terminal_count));
        end
        $display("test gating done");
        {own_gate_pin, terminal_count} = 10'h000;
        mode[0] = '{GATE_EDGE_RISE, 1'b0, 1'b0};
        mode[3] = '{GATE_NONE, 1'b1, 1'b0};
        repeat (4) @(negedge ref_clk);
        own_gate_pin[0] = 1'b1;
        wait_en();
        own_gate_pin[0] = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("edge_hold", count_enable[0], 1'b1);
        tc_pulse(0);
        chk("auto_disarm", armed[0], 1'b0);
        mode[0].repetition_bit = 1'b1;
        cmd(8'h21);
        own_gate_pin[0] = 1'b1;
        wait_en();
        tc_pulse(0);
        chk("rep_armed", armed[0], 1'b1);
        chk("edge_stop", count_enable[0], 1'b0);
        own_gate_pin[0] = 1'b0;
        repeat (4) @(negedge ref_clk);
        own_gate_pin[0] = 1'b1;
        wait_en();
        chk("retrigger", count_enable[0], 1'b1);
        terminal_count[3] = 1'b1;
        @(negedge ref_clk);
        cmd(8'hc8);
        chk("defer", armed[3], 1'b1);
        tc_pulse(3);
        chk("deferred", armed[3], 1'b0);
        mode[1] = '{GATE_NONE, 1'b1, 1'b1};
        cmd(8'h22);
        chk("hold_first", reload_from_hold[1], 1'b1);
        tc_pulse(1);
        chk("alternate", reload_from_hold[1], 1'b0);
        $display("test edge done");
        cmd(8'he9);
        cmd(CODE_BUS_WIDE);
        cmd(CODE_MASTER_RESET);
        repeat (3) @(negedge ref_clk);
        chk("mr_state", {armed, toggle_state, master_mode}, 14'h0000);
        chk("mr_pointer", data_pointer, POINTER_RESET);
        $display("test reset done");
        test_done();
    end
endmodule
`default_nettype wire
